/* rtl/port6.sv */
`timescale 1ns/1ns
`include "port6_cfg.svh"

//
// Contract
// (R1) direction register reads back all ones
// (R2) direction bits 7..3 reserved, bit7 fixed one
// (R3) pin7 clock out unless disable bit set
// (R4) io pins: direction 1 drives, 0 inputs
// (R5) direction resets 0x80, holds in soft standby
// (R6) soft standby keeps driving output pins
// (R7) output pins drive data register bits
// (R8) data bit7 reads 1 or pin7 level
// (R9) data bits 6..3 plain storage
// (R10) io read: pin if input, latch if output
// (R11) data resets 0x80, holds in soft standby
// (R12) bus release swaps pins 2,1 to bus
// (R13) stall enable makes pin0 stall input
//
module port6 #(
	parameter int CLK_DIV = `CLK_DIV_DEFAULT
) (
	// clock and resets
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic hw_standby_i,
	input wire logic sw_standby_i,
	// register port
	input wire port6_pkg::reg_req_t req_i,
	output logic [7:0] rdata_o,
	// pin mode selects
	input wire port6_pkg::pin_mode_t mode_i,
	// bus controller side
	input wire port6_pkg::bus_out_t bus_out_i,
	output port6_pkg::bus_in_t bus_in_o,
	// pins: level in, level out, enable low while driven
	input wire logic [7:0] pin_i,
	output logic [7:0] pin_o,
	output logic [7:0] pin_oe_n_o
);

	// ***********************************
	// pin input synchronisers
	// ***********************************
	logic [3:0] pin_raw;
	logic [3:0] pin_s;

	assign pin_raw = {pin_i[`CLOCK_PIN_BIT], pin_i[2:0]};

	pin_sync #(
		.WIDTH(4)
	) u_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i(pin_raw),
		.sync_o(pin_s)
	);

	// ***********************************
	// registers
	// ***********************************
	logic [2:0] dir_q;
	logic [2:0] dir_d;
	logic [7:0] data_q;
	logic [7:0] data_d;
	logic wr_dir;
	logic wr_data;
	logic rd_dir;
	logic rd_data;

	// address decode
	always_comb begin
		wr_dir = req_i.wr && (req_i.addr == `PORT_DIRECTION_ADDR);
		wr_data = req_i.wr && (req_i.addr == `PORT_DATA_ADDR);
		rd_dir = req_i.rd && (req_i.addr == `PORT_DIRECTION_ADDR);
		rd_data = req_i.rd && (req_i.addr == `PORT_DATA_ADDR);
	end

	// writes; standby other than hardware keeps contents
	always_comb begin
		dir_d = dir_q;
		data_d = data_q;
		if (wr_dir) begin
			dir_d = req_i.wdata[2:0]; // [R2]
		end
		if (wr_data) begin
			data_d[`STORE_MSB:0] = req_i.wdata[`STORE_MSB:0]; // [R9]
		end
		data_d[`CLOCK_PIN_BIT] = 1'b1; // [R8]
	end

	// hardware standby reinitialises like reset
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dir_q <= 3'h0; // [R5]
			data_q <= `PORT_DATA_RESET; // [R11]
		end else if (hw_standby_i) begin
			dir_q <= 3'h0; // [R5]
			data_q <= `PORT_DATA_RESET; // [R11]
		end else begin
			dir_q <= dir_d;
			data_q <= data_d;
		end
	end

	// ***********************************
	// read data
	// ***********************************
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic [7:0] data_view;

	// read view of the data register
	always_comb begin
		data_view = data_q;
		data_view[`CLOCK_PIN_BIT] = mode_i.clock_pin_disable ?
			pin_s[3] : 1'b1; // [R8]
		for (int i = 0; i < `IO_PIN_COUNT; i++) begin
			data_view[i] = dir_q[i] ? data_q[i] : pin_s[i]; // [R10]
		end
	end

	// one-cycle read answer
	always_comb begin
		rdata_d = `UNMAPPED_READ;
		if (rd_dir) begin
			rdata_d = `DIRECTION_READBACK; // [R1]
		end else if (rd_data) begin
			rdata_d = data_view;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;

	// ***********************************
	// clock output divider
	// ***********************************
	logic [15:0] div_q;
	logic [15:0] div_d;
	logic clk_out_q;
	logic clk_out_d;

	// toggles every CLK_DIV cycles
	always_comb begin
		div_d = div_q + 16'h0001;
		clk_out_d = clk_out_q;
		if (div_q >= 16'(CLK_DIV - 1)) begin
			div_d = 16'h0000;
			clk_out_d = ~clk_out_q;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_q <= 16'h0000;
			clk_out_q <= 1'b0;
		end else begin
			div_q <= div_d;
			clk_out_q <= clk_out_d;
		end
	end

	// ***********************************
	// pin muxing
	// ***********************************
	logic [7:0] pin_d;
	logic [7:0] oe_n_d;
	logic [7:0] pin_q;
	logic [7:0] oe_n_q;
	port6_pkg::bus_in_t bus_in_d;
	port6_pkg::bus_in_t bus_in_q;

	// per-pin function select; software standby does not alter drive
	always_comb begin
		pin_d = 8'h00;
		oe_n_d = 8'hFF;
		for (int i = 0; i < `IO_PIN_COUNT; i++) begin
			pin_d[i] = data_q[i]; // [R7]
			oe_n_d[i] = ~dir_q[i]; // [R4] [R6]
		end
		if (!mode_i.clock_pin_disable) begin
			pin_d[`CLOCK_PIN_BIT] = clk_out_q; // [R3]
			oe_n_d[`CLOCK_PIN_BIT] = 1'b0; // [R3]
		end
		if (mode_i.bus_release_enable) begin
			pin_d[`GRANT_PIN_BIT] = bus_out_i.bus_grant_n; // [R12]
			oe_n_d[`GRANT_PIN_BIT] = 1'b0; // [R12]
			oe_n_d[`REQUEST_PIN_BIT] = 1'b1; // [R12]
			pin_d[`REQUEST_PIN_BIT] = 1'b0;
		end
		if (mode_i.stall_pin_enable) begin
			oe_n_d[`STALL_PIN_BIT] = 1'b1; // [R13]
			pin_d[`STALL_PIN_BIT] = 1'b0;
		end
		bus_in_d.bus_request_in_n = mode_i.bus_release_enable ?
			pin_s[`REQUEST_PIN_BIT] : 1'b1; // [R12]
		bus_in_d.stall_request_n = mode_i.stall_pin_enable ?
			pin_s[`STALL_PIN_BIT] : 1'b1; // [R13]
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_q <= 8'h00;
			oe_n_q <= 8'hFF;
			bus_in_q <= 2'b11;
		end else begin
			pin_q <= pin_d;
			oe_n_q <= oe_n_d;
			bus_in_q <= bus_in_d;
		end
	end

	assign pin_o = pin_q;
	assign pin_oe_n_o = oe_n_q;
	assign bus_in_o = bus_in_q;

endmodule

/* rtl/port6_cfg.svh */
`ifndef PORT6_CFG_SVH
`define PORT6_CFG_SVH

// ***********************************
// register map
// ***********************************
`define ADDR_W 20
`define PORT_DIRECTION_ADDR 20'hEE005
`define PORT_DATA_ADDR 20'hFFFD5
`define PORT_DIRECTION_RESET 8'h80
`define PORT_DATA_RESET 8'h80
`define DIRECTION_READBACK 8'hFF
`define UNMAPPED_READ 8'h00

// ***********************************
// field positions
// ***********************************
`define CLOCK_PIN_BIT 7
`define GRANT_PIN_BIT 2
`define REQUEST_PIN_BIT 1
`define STALL_PIN_BIT 0
`define IO_PIN_COUNT 3
`define STORE_LSB 3
`define STORE_MSB 6

// ***********************************
// clock output divider
// ***********************************
`define CLK_DIV_DEFAULT 1

`endif

/* rtl/port6_pkg.sv */
package port6_pkg;

	// register bus request
	typedef struct packed {
		logic [19:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// mode selects coming from other controllers
	typedef struct packed {
		logic clock_pin_disable;
		logic bus_release_enable;
		logic stall_pin_enable;
	} pin_mode_t;

	// bus-function signals to and from the bus controller
	typedef struct packed {
		logic bus_grant_n;
	} bus_out_t;

	typedef struct packed {
		logic bus_request_in_n;
		logic stall_request_n;
	} bus_in_t;

endpackage

/* rtl/pin_sync.sv */
`timescale 1ns/1ns
`include "port6_cfg.svh"

// two-flop synchroniser for a vector of pin levels
module pin_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// pins in, synchronised out
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// first stage feeds only the second
	always_comb begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	// both stages reset low
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;

endmodule

/* testbench/port6_monitor.sv */
`timescale 1ns/1ns
// port rule checker
module port6_monitor (
	// clock and resets
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic hw_standby_i,
	input wire logic sw_standby_i,
	// bus and pins
	input wire port6_pkg::reg_req_t req_i,
	input wire logic [7:0] rdata_o,
	input wire port6_pkg::pin_mode_t mode_i,
	input wire port6_pkg::bus_out_t bus_out_i,
	input wire port6_pkg::bus_in_t bus_in_o,
	input wire logic [7:0] pin_i,
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// data register accesses
	wire rd_d = req_i.rd && req_i.addr == 20'hFFFD5;
	wire wr_d = req_i.wr && req_i.addr == 20'hFFFD5;
	a_dir_reads_ones: assert property (
		req_i.rd && req_i.addr == 20'hEE005 |=> rdata_o == 8'hFF) else $error("dir read");
	a_clk_pin_drive: assert property (
		!mode_i.clock_pin_disable |=> !pin_oe_n_o[7]) else $error("clock pin idle");
	a_clk_pin_input: assert property (
		mode_i.clock_pin_disable |=> pin_oe_n_o[7]) else $error("clock pin driven");
	// clock pin level follows the divider, which toggles each cycle at the default divide
	a_clk_pin_toggles: assert property (
		!mode_i.clock_pin_disable ##1 !mode_i.clock_pin_disable |=> pin_o[7] != $past(pin_o[7]))
		else $error("clock pin still");
	a_grant_pin_out: assert property (
		mode_i.bus_release_enable |=> !pin_oe_n_o[2] && pin_o[2] == $past(bus_out_i.bus_grant_n))
		else $error("grant pin");
	a_request_pin_in: assert property (
		mode_i.bus_release_enable |=> pin_oe_n_o[1]) else $error("request pin driven");
	a_stall_pin_in: assert property (
		mode_i.stall_pin_enable |=> pin_oe_n_o[0]) else $error("stall pin driven");
	a_data_bit_seven: assert property (
		rd_d && !mode_i.clock_pin_disable |=> rdata_o[7]) else $error("bit7 not one");
	a_store_bits_keep: assert property (
		wr_d ##2 rd_d |=> rdata_o[6:3] == $past(req_i.wdata[6:3], 3)) else $error("store bits");
	// main scenarios
	cover property (wr_d ##2 rd_d);
	cover property (mode_i.bus_release_enable && mode_i.stall_pin_enable);
	cover property (sw_standby_i && !pin_oe_n_o[0]);
endmodule

/* testbench/pin_world.sv */
`timescale 1ns/1ns
// outside world: driven pads read back, released pads take outside level
module pin_world (
	input wire logic [7:0] drv_i,
	input wire logic [7:0] oe_n_i,
	input wire logic [7:0] ext_i,
	output logic [7:0] lvl_o
);
	assign lvl_o = (oe_n_i & ext_i) | (~oe_n_i & drv_i);
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ns
module testbench;
	logic clk_i = 0;
	logic sys_rst_i = 1;
	logic hw_standby_i = 0;
	logic sw_standby_i = 0;
	port6_pkg::reg_req_t req_i = '0;
	port6_pkg::pin_mode_t mode_i = '0;
	port6_pkg::bus_out_t bus_out_i = '1;
	port6_pkg::bus_in_t bus_in_o;
	logic [7:0] rdata_o, pin_i, pin_o, pin_oe_n_o;
	logic [7:0] ext = '0;
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	localparam logic [19:0] DIR = 20'hEE005;
	localparam logic [19:0] DAT = 20'hFFFD5;
	port6 u_port6 (.clk_i, .sys_rst_i, .hw_standby_i, .sw_standby_i, .req_i, .rdata_o,
		.mode_i, .bus_out_i, .bus_in_o, .pin_i, .pin_o, .pin_oe_n_o);
	pin_world u_pin_world (.drv_i(pin_o), .oe_n_i(pin_oe_n_o), .ext_i(ext), .lvl_o(pin_i));
	initial forever #20 clk_i = ~clk_i;
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("fails %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// one-cycle strobes, one idle cycle after
	task wr(input logic [19:0] a, input logic [7:0] d);
		req_i <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_i);
		req_i <= '0;
		@(posedge clk_i);
	endtask
	task rd(input logic [19:0] a, input logic [7:0] exp);
		req_i <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_i);
		req_i <= '0;
		@(negedge clk_i);
		chk(rdata_o, exp);
		@(posedge clk_i);
	endtask
	// hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			test_done;
		end
	end
	initial begin
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 0;
		@(posedge clk_i);
		rd(DIR, 8'hFF);
		rd(DAT, 8'h80);
		rd(20'h00000, 8'h00);
		wr(DIR, 8'hFF);
		wr(DAT, 8'h2D);
		rd(DAT, 8'hAD);
		chk(pin_o & 8'h07, 8'h05);
		chk(pin_oe_n_o & 8'h87, 8'h00);
		sw_standby_i <= 1;
		ext <= 8'hFF;
		repeat (5) @(posedge clk_i);
		chk(pin_o & 8'h07, 8'h05);
		rd(DAT, 8'hAD);
		chk(pin_oe_n_o & 8'h07, 8'h00);
		sw_standby_i <= 0;
		ext <= 8'h02;
		wr(DIR, 8'h00);
		repeat (3) @(posedge clk_i);
		rd(DAT, 8'hAA);
		chk(pin_oe_n_o & 8'h07, 8'h07);
		mode_i.clock_pin_disable <= 1;
		repeat (3) @(posedge clk_i);
		rd(DAT, 8'h2A);
		chk(pin_oe_n_o & 8'h80, 8'h80);
		wr(DIR, 8'h07);
		hw_standby_i <= 1;
		@(posedge clk_i);
		hw_standby_i <= 0;
		repeat (3) @(posedge clk_i);
		rd(DAT, 8'h02);
		wr(DIR, 8'h06);
		ext <= 8'h01;
		mode_i <= '{1'b1, 1'b1, 1'b1};
		bus_out_i <= '0;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk(pin_oe_n_o & 8'h07, 8'h03);
		chk(pin_o & 8'h04, 8'h00);
		chk({6'h00, bus_in_o}, 8'h01);
		test_done;
	end
endmodule
bind port6 port6_monitor u_port6_monitor (.clk_i, .sys_rst_i, .hw_standby_i, .sw_standby_i,
	.req_i, .rdata_o, .mode_i, .bus_out_i, .bus_in_o, .pin_i, .pin_o, .pin_oe_n_o);
